// ==== core/tmr_core.sv ====
// Sixteen-bit timer with capture, auto-reload and baud generation
// Notes on behaviour
// RQ1: Overflow flag set only when both baud bits clear
// RQ2: Only software clears overflow flag; may set it
// RQ3: Trigger falling edge sets external event flag
// RQ4: Edge-set external event flag stays until cleared
// RQ5: Event flag set raises enabled timer interrupt
// RQ6: Receive clock from timer 1 or ours
// RQ7: Transmit clock from timer 1 or ours
// RQ8: Any baud bit selects baud generator mode
// RQ9: Trigger ignored unless enabled and not baud
// RQ10: Run bit starts, stops, holds count
// RQ11: Source bit picks clock or event counting
// RQ12: Baud mode ticks once every two clocks
// RQ13: Baud mode always auto-reloads on overflow
// RQ14: Reload mode: overflow and enabled trigger reload
// RQ15: Capture mode: enabled trigger captures count
// RQ16: Capture copies count; reload loads capture
// RQ17: Counter mode counts synced input falling edges
// RQ18: Overflow is all-ones rollover, same-cycle effects
`timescale 1ns/100ps
module tmr_core
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Pins and serial side
  input wire logic trigger_input_i,
  input wire logic count_input_i,
  input wire logic t1_overflow_i,
  input wire logic serial_mode13_i,
  input wire logic timer_irq_en_i,
  output tmr_pkg::tmr_baud_s baud_o,
  output logic timer_irq_o,
  output logic irq_o
);
  import tmr_pkg::*;

  tmr_state_s s_r;
  tmr_state_s s_nxt;

  logic baud_mode;
  logic trig_fall;
  logic cin_fall;
  logic tick;
  logic ovf;
  logic [7:0] ctrl_w;
  // Status sets and clears gathered in this cycle
  logic [1:0] ist_set;
  logic [1:0] ist_clr;
  logic ctrl_wr;
  logic trig_act;

  assign rdata_o = s_r.rdata;
  assign baud_o = s_r.baud;
  assign timer_irq_o = s_r.timer_irq;
  assign irq_o = s_r.irq;

  // Qualifiers shared by the checks below
  assign ctrl_wr = wr_i && (addr_i == TMR_CTRL_ADDR);
  assign trig_act = trig_fall & s_r.ctrl[TMR_TEN_BIT] & ~baud_mode;

  // Next state of the whole block
  always_comb begin
    s_nxt = s_r;
    ctrl_w = s_r.ctrl;
    // Sets and clears are merged once, so a set can never be lost
    ist_set = 2'b00;
    ist_clr = 2'b00;
    // Pins pass two flops; edges look only at the second stage onward
    s_nxt.trig_sy = {s_r.trig_sy[0], trigger_input_i};
    s_nxt.trig_d = s_r.trig_sy[1];
    s_nxt.cin_sy = {s_r.cin_sy[0], count_input_i};
    s_nxt.cin_d = s_r.cin_sy[1];
    trig_fall = s_r.trig_d & ~s_r.trig_sy[1];
    cin_fall = s_r.cin_d & ~s_r.cin_sy[1]; // see RQ17
    baud_mode = s_r.ctrl[TMR_RXB_BIT] | s_r.ctrl[TMR_TXB_BIT]; // see RQ8
    // Prescaler only runs in baud mode so the first tick is predictable
    s_nxt.pre = baud_mode & s_r.ctrl[TMR_RUN_BIT] ? ~s_r.pre : 1'b0;
    if (baud_mode) begin
      tick = s_r.pre; // see RQ12
    end else if (s_r.ctrl[TMR_SRC_BIT]) begin
      tick = cin_fall; // see RQ11
    end else begin
      tick = 1'b1;
    end
    tick = tick & s_r.ctrl[TMR_RUN_BIT]; // see RQ10
    ovf = tick & (s_r.cnt == 16'hffff); // see RQ18
    // Software write to the control register first; hardware sets win after
    if (wr_i && addr_i == TMR_CTRL_ADDR) begin
      ctrl_w = wdata_i; // see RQ2
    end
    s_nxt.ctrl = ctrl_w;
    if (tick) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
    if (ovf) begin
      if (baud_mode || !s_r.ctrl[TMR_CRS_BIT]) begin
        s_nxt.cnt = s_r.cap; // see RQ13 RQ14 RQ16
      end
      if (!baud_mode) begin
        s_nxt.ctrl[TMR_OVF_BIT] = 1'b1; // see RQ1
        ist_set[TMR_IS_OVF_BIT] = 1'b1;
      end
    end
    // Trigger edges act only when enabled and not generating baud clocks
    if (trig_fall && s_r.ctrl[TMR_TEN_BIT] && !baud_mode) begin // see RQ9
      s_nxt.ctrl[TMR_EXT_BIT] = 1'b1; // see RQ3 RQ4
      ist_set[TMR_IS_EXT_BIT] = 1'b1;
      if (s_r.ctrl[TMR_CRS_BIT]) begin
        s_nxt.cap = s_r.cnt; // see RQ15 RQ16
      end else begin
        s_nxt.cnt = s_r.cap; // see RQ14
      end
    end
    // Register writes to count, capture and mask bytes
    if (wr_i) begin
      case (addr_i)
        TMR_CAPL_ADDR: s_nxt.cap[7:0] = wdata_i;
        TMR_CAPH_ADDR: s_nxt.cap[15:8] = wdata_i;
        TMR_CNTL_ADDR: s_nxt.cnt[7:0] = wdata_i;
        TMR_CNTH_ADDR: s_nxt.cnt[15:8] = wdata_i;
        TMR_IMASK_ADDR: s_nxt.imask = wdata_i[1:0];
        default: ;
      endcase
    end
    // Read data one cycle later; status read clears, but a new set wins
    s_nxt.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        TMR_CTRL_ADDR: s_nxt.rdata = s_r.ctrl;
        TMR_CAPL_ADDR: s_nxt.rdata = s_r.cap[7:0];
        TMR_CAPH_ADDR: s_nxt.rdata = s_r.cap[15:8];
        TMR_CNTL_ADDR: s_nxt.rdata = s_r.cnt[7:0];
        TMR_CNTH_ADDR: s_nxt.rdata = s_r.cnt[15:8];
        TMR_ISTAT_ADDR: begin
          s_nxt.rdata = {6'h00, s_r.ist};
          // Clear only the bits this read returned
          ist_clr = s_r.ist;
        end
        TMR_IMASK_ADDR: s_nxt.rdata = {6'h00, s_r.imask};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    // Software-set event flag also requests the timer interrupt
    if (ctrl_w[TMR_EXT_BIT] && !s_r.ctrl[TMR_EXT_BIT]) begin
      ist_set[TMR_IS_EXT_BIT] = 1'b1; // see RQ5
    end
    // A read clears what it returned; a set in the same cycle wins
    s_nxt.ist = (s_r.ist & ~ist_clr) | ist_set;
    // Baud clocks follow the selected overflow source
    s_nxt.baud.rx_clk = serial_mode13_i & (s_r.ctrl[TMR_RXB_BIT] ? ovf : t1_overflow_i); // see RQ6
    s_nxt.baud.tx_clk = serial_mode13_i & (s_r.ctrl[TMR_TXB_BIT] ? ovf : t1_overflow_i); // see RQ7
    s_nxt.timer_irq = timer_irq_en_i & (s_nxt.ctrl[TMR_OVF_BIT] | s_nxt.ctrl[TMR_EXT_BIT]); // see RQ5
    s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
  end

  // State register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '0;
      s_r.ctrl <= TMR_CTRL_RST;
      s_r.cnt <= TMR_CNT_RST;
      s_r.cap <= TMR_CAP_RST;
      s_r.ist <= TMR_IRQ_RST;
      s_r.imask <= TMR_IRQ_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Hardware raises the overflow flag only from a rollover outside baud mode
  ovf_flag_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ1
    (ovf && baud_mode && !(wr_i && addr_i == TMR_CTRL_ADDR) && !$past(s_r.ctrl[TMR_OVF_BIT], 1) && !s_r.ctrl[TMR_OVF_BIT])
      |=> !s_r.ctrl[TMR_OVF_BIT])
    else $error("overflow flag set in baud mode");
  ovf_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ2
    (s_r.ctrl[TMR_OVF_BIT] && !(wr_i && addr_i == TMR_CTRL_ADDR)) |=> s_r.ctrl[TMR_OVF_BIT])
    else $error("overflow flag cleared by hardware");
  ext_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ4
    (s_r.ctrl[TMR_EXT_BIT] && !(wr_i && addr_i == TMR_CTRL_ADDR)) |=> s_r.ctrl[TMR_EXT_BIT])
    else $error("event flag cleared by hardware");
  ext_set_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ3
    (trig_fall && s_r.ctrl[TMR_TEN_BIT] && !baud_mode) |=> s_r.ctrl[TMR_EXT_BIT] && s_r.ist[TMR_IS_EXT_BIT])
    else $error("trigger edge did not set event flag");
  run_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ10
    (!s_r.ctrl[TMR_RUN_BIT] && !wr_i && !trig_fall) |=> s_r.cnt == $past(s_r.cnt))
    else $error("count moved while stopped");
  baud_tick_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ12
    (baud_mode && tick && !wr_i) |=> !tick)
    else $error("baud mode ticked on adjacent clocks");
  baud_reload_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ13
    (ovf && baud_mode && !wr_i) |=> s_r.cnt == $past(s_r.cap))
    else $error("no reload after baud overflow");
  cap_copy_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ15
    (trig_fall && s_r.ctrl[TMR_TEN_BIT] && !baud_mode && s_r.ctrl[TMR_CRS_BIT] && !wr_i)
      |=> s_r.cap == $past(s_r.cnt))
    else $error("capture did not copy count");
  rx_src_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ6
    (serial_mode13_i && !s_r.ctrl[TMR_RXB_BIT]) |=> baud_o.rx_clk == $past(t1_overflow_i))
    else $error("receive clock source wrong");

  // Further checks on flags, sources and counting. Register writes are
  // left out of an antecedent only where software may override hardware,
  // so each check still bites on the plain hardware path.

  // Outside baud mode a rollover raises flag and status together
  ovf_set_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ1 RQ18
    (ovf && !baud_mode)
      |=> s_r.ctrl[TMR_OVF_BIT] && s_r.ist[TMR_IS_OVF_BIT])
    else $error("rollover did not raise overflow flag");

  // Transmit clock follows timer 1 while its select bit is clear
  tx_src_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ7
    (serial_mode13_i && !s_r.ctrl[TMR_TXB_BIT])
      |=> baud_o.tx_clk == $past(t1_overflow_i))
    else $error("transmit clock source wrong");

  // Receive clock follows our own rollover once selected
  rx_own_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ6
    (serial_mode13_i && s_r.ctrl[TMR_RXB_BIT])
      |=> baud_o.rx_clk == $past(ovf))
    else $error("receive clock not from own rollover");

  // Transmit clock follows our own rollover once selected
  tx_own_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ7
    (serial_mode13_i && s_r.ctrl[TMR_TXB_BIT])
      |=> baud_o.tx_clk == $past(ovf))
    else $error("transmit clock not from own rollover");

  // Reload mode: a rollover loads the capture value
  ovf_reload_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ14
    (ovf && !baud_mode && !s_r.ctrl[TMR_CRS_BIT] && !wr_i)
      |=> s_r.cnt == $past(s_r.cap))
    else $error("no reload after rollover");

  // Reload mode: an enabled trigger edge loads the capture value
  trig_reload_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ14
    (trig_act && !s_r.ctrl[TMR_CRS_BIT] && !wr_i)
      |=> s_r.cnt == $past(s_r.cap))
    else $error("no reload after trigger edge");

  // Timer operation advances on every clock while running
  timer_step_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ11
    (s_r.ctrl[TMR_RUN_BIT] && !s_r.ctrl[TMR_SRC_BIT] && !baud_mode && !ovf && !trig_act && !wr_i)
      |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("timer did not advance by one");

  // Counter operation advances only on a synchronised falling edge
  event_step_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ17
    (s_r.ctrl[TMR_RUN_BIT] && s_r.ctrl[TMR_SRC_BIT] && !baud_mode && !ovf && !trig_act && !wr_i)
      |=> s_r.cnt == $past(s_r.cnt) + {15'h0000, $past(cin_fall)})
    else $error("counter step does not match input edges");

  // Software setting the event flag raises its status bit
  sw_event_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ5
    (ctrl_wr && wdata_i[TMR_EXT_BIT] && !s_r.ctrl[TMR_EXT_BIT])
      |=> s_r.ist[TMR_IS_EXT_BIT])
    else $error("software event set gave no status");

  // An accepted trigger edge requests the timer interrupt when enabled
  irq_trig_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ5
    (trig_act && timer_irq_en_i)
      |=> timer_irq_o)
    else $error("trigger edge gave no timer interrupt");

  // A refused trigger edge leaves flag and capture alone
  trig_off_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ9
    (trig_fall && !trig_act && !wr_i && !s_r.ctrl[TMR_EXT_BIT])
      |=> !s_r.ctrl[TMR_EXT_BIT] && s_r.cap == $past(s_r.cap))
    else $error("refused trigger edge had an effect");

  // Capture bytes change only by a capture or a write
  cap_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ16
    (!wr_i && !(trig_act && s_r.ctrl[TMR_CRS_BIT]))
      |=> s_r.cap == $past(s_r.cap))
    else $error("capture bytes moved on their own");

  // Either select bit puts the timer in baud mode
  baud_sel_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ8
    (ctrl_wr && (wdata_i[TMR_RXB_BIT] || wdata_i[TMR_TXB_BIT]))
      |=> baud_mode)
    else $error("baud select did not enter baud mode");

  // Prescaler rests outside baud mode, so the first tick is two clocks in
  pre_idle_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ12
    (!baud_mode)
      |=> !s_r.pre)
    else $error("prescaler ran outside baud mode");

  // A rollover never sets the event flag by itself
  ext_no_ovf_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ3
    (ovf && !ctrl_wr && !trig_act && !s_r.ctrl[TMR_EXT_BIT])
      |=> !s_r.ctrl[TMR_EXT_BIT])
    else $error("rollover set the event flag");

  // Software may set or clear any control bit, flags included
  ctrl_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ2
    (ctrl_wr && !(ovf && !baud_mode) && !trig_act)
      |=> s_r.ctrl == $past(wdata_i))
    else $error("control write did not land");

  // A status read with no new event leaves the status empty
  stat_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (rd_i && addr_i == TMR_ISTAT_ADDR && !ovf && !trig_act && !ctrl_wr)
      |=> s_r.ist == 2'b00)
    else $error("status read did not clear");

  // Interrupt line tracks masked status level
  irq_level_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    irq_o == |(s_r.ist & s_r.imask))
    else $error("interrupt line disagrees with status");

  // Read data stand one cycle only
  rdata_idle_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (!rd_i)
      |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");

  // Count byte writes win over hardware in the same cycle
  cnt_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (wr_i && addr_i == TMR_CNTL_ADDR)
      |=> s_r.cnt[7:0] == $past(wdata_i))
    else $error("count low write did not land");

  // Capture byte writes win over a capture in the same cycle
  cap_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RQ16
    (wr_i && addr_i == TMR_CAPH_ADDR)
      |=> s_r.cap[15:8] == $past(wdata_i))
    else $error("capture high write did not land");

  // Mask writes land as written
  mask_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (wr_i && addr_i == TMR_IMASK_ADDR)
      |=> s_r.imask == $past(wdata_i[1:0]))
    else $error("mask write did not land");
endmodule

// ==== core/tmr_pkg.sv ====
// Package for the sixteen-bit capture / reload / baud timer
package tmr_pkg;
  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] TMR_CTRL_ADDR = 8'hc8;
  localparam logic [7:0] TMR_CAPL_ADDR = 8'hca;
  localparam logic [7:0] TMR_CAPH_ADDR = 8'hcb;
  localparam logic [7:0] TMR_CNTL_ADDR = 8'hcc;
  localparam logic [7:0] TMR_CNTH_ADDR = 8'hcd;
  localparam logic [7:0] TMR_ISTAT_ADDR = 8'he8;
  localparam logic [7:0] TMR_IMASK_ADDR = 8'he9;
  // Control field positions
  localparam int TMR_OVF_BIT = 7;
  localparam int TMR_EXT_BIT = 6;
  localparam int TMR_RXB_BIT = 5;
  localparam int TMR_TXB_BIT = 4;
  localparam int TMR_TEN_BIT = 3;
  localparam int TMR_RUN_BIT = 2;
  localparam int TMR_SRC_BIT = 1;
  localparam int TMR_CRS_BIT = 0;
  // Interrupt status layout
  localparam int TMR_IS_OVF_BIT = 0;
  localparam int TMR_IS_EXT_BIT = 1;
  // Reset values
  localparam logic [7:0] TMR_CTRL_RST = 8'h00;
  localparam logic [15:0] TMR_CNT_RST = 16'h0000;
  localparam logic [15:0] TMR_CAP_RST = 16'h0000;
  localparam logic [1:0] TMR_IRQ_RST = 2'h0;
  // Baud tick every two clocks
  localparam int TMR_BAUD_DIV = 2;

  typedef struct packed {
    logic rx_clk;
    logic tx_clk;
  } tmr_baud_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [1:0] ist;
    logic [1:0] imask;
    logic [7:0] rdata;
    logic [1:0] trig_sy;
    logic trig_d;
    logic [1:0] cin_sy;
    logic cin_d;
    logic pre;
    tmr_baud_s baud;
    logic irq;
    logic timer_irq;
  } tmr_state_s;
endpackage

// ==== tb/tmr_pin_model.sv ====
// Pin-side model: trigger, count input and timer 1
`timescale 1ns/100ps
module tmr_pin_model (
  // Clock
  input wire logic clock_i,
  // Pins toward the timer
  output logic trig_o,
  output logic cnt_o,
  output logic t1_ovf_o,
  output logic mode13_o
);
  logic [2:0] div_r = 3'h0;
  // Trigger and count pins idle high, timer 1 overflow idles low; serial port stays in a variable-rate mode
  initial begin
    trig_o = 1'b1;
    cnt_o = 1'b1;
    t1_ovf_o = 1'b0;
    mode13_o = 1'b1;
  end
  // Timer 1 overflows every eight clocks
  always @(posedge clock_i) begin
    div_r <= div_r + 3'h1;
    t1_ovf_o <= (div_r == 3'h7);
  end
  // Low for four clocks so the fall outlives the synchroniser
  task automatic fall(input bit sel);
    @(posedge clock_i);
    if (sel)
      cnt_o <= 1'b0;
    else
      trig_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    cnt_o <= 1'b1;
    trig_o <= 1'b1;
    repeat (4) @(posedge clock_i);
  endtask
endmodule

// ==== tb/tmr_core_test.sv ====
// Self-checking bench for the capture, reload and baud timer
`timescale 1ns/100ps
module tmr_core_test;
  import tmr_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic irq_en = 1'b1;
  logic [7:0] rdata_o;
  logic trig, cnt, t1_ovf, mode13, timer_irq_o, irq_o;
  tmr_baud_s baud_o;
  logic [31:0] seed = 32'h45084410;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_rx, n_tx;
  always #5 clock_i = ~clock_i;
  tmr_pin_model pin_u (.clock_i(clock_i), .trig_o(trig), .cnt_o(cnt), .t1_ovf_o(t1_ovf), .mode13_o(mode13));
  tmr_core dut_u (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .trigger_input_i(trig), .count_input_i(cnt), .t1_overflow_i(t1_ovf),
    .serial_mode13_i(mode13), .timer_irq_en_i(irq_en), .baud_o(baud_o), .timer_irq_o(timer_irq_o), .irq_o(irq_o));
  // Random byte source, repeatable from its seed
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(nm, e, rdata_o);
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  initial begin
    #900000;
    n_mismatch++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    rchk(TMR_CTRL_ADDR, TMR_CTRL_RST, "ctrl rst");
    rchk(TMR_CNTH_ADDR, TMR_CNT_RST[15:8], "cnt rst");
    rchk(8'h00, 8'h00, "unmapped");
    // Roll over from all ones, reload a small random value
    seed = lfsr(seed);
    wr(TMR_CAPL_ADDR, {1'b0, seed[6:0]});
    wr(TMR_CAPH_ADDR, 8'h00);
    wr(TMR_CNTL_ADDR, 8'hfe);
    wr(TMR_CNTH_ADDR, 8'hff);
    wr(TMR_IMASK_ADDR, 8'h01);
    wr(TMR_CTRL_ADDR, 8'h04);
    repeat (10) @(posedge clock_i);
    rchk(TMR_CTRL_ADDR, 8'h84, "ovf flag");
    wr(TMR_CTRL_ADDR, 8'h80);
    rchk(TMR_CNTH_ADDR, 8'h00, "reload");
    wr(TMR_CNTL_ADDR, 8'h33);
    repeat (6) @(posedge clock_i);
    rchk(TMR_CNTL_ADDR, 8'h33, "halted");
    chk("irq", 8'h01, {7'h0, irq_o});
    rchk(TMR_ISTAT_ADDR, 8'h01, "status");
    rchk(TMR_ISTAT_ADDR, 8'h00, "cleared");
    chk("irq off", 8'h00, {7'h0, irq_o});
    rchk(TMR_CTRL_ADDR, 8'h80, "flag kept");
    // Capture on a trigger fall, then reload on one
    seed = lfsr(seed);
    wr(TMR_CNTL_ADDR, seed[7:0]);
    wr(TMR_CNTH_ADDR, 8'h5a);
    wr(TMR_CTRL_ADDR, 8'h09);
    pin_u.fall(1'b0);
    rchk(TMR_CAPL_ADDR, seed[7:0], "cap lo");
    rchk(TMR_CAPH_ADDR, 8'h5a, "cap hi");
    rchk(TMR_CTRL_ADDR, 8'h49, "event");
    chk("timer irq", 8'h01, {7'h0, timer_irq_o});
    @(posedge clock_i);
    irq_en <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1 chk("timer irq off", 8'h00, {7'h0, timer_irq_o});
    @(posedge clock_i);
    irq_en <= 1'b1;
    wr(TMR_CNTH_ADDR, 8'h00);
    wr(TMR_CTRL_ADDR, 8'h08);
    pin_u.fall(1'b0);
    rchk(TMR_CNTH_ADDR, 8'h5a, "trig reload");
    wr(TMR_CTRL_ADDR, 8'h01);
    pin_u.fall(1'b0);
    rchk(TMR_CTRL_ADDR, 8'h01, "ignored");
    // Baud mode: overflow every four clocks, or timer 1 for receive
    wr(TMR_CAPL_ADDR, 8'hfe);
    wr(TMR_CAPH_ADDR, 8'hff);
    for (int m = 0; m < 2; m++) begin
      wr(TMR_CNTL_ADDR, 8'hfe);
      wr(TMR_CNTH_ADDR, 8'hff);
      wr(TMR_CTRL_ADDR, m ? 8'h1c : 8'h3c);
      n_rx = 0;
      n_tx = 0;
      repeat (80) begin
        @(posedge clock_i);
        #1 n_rx += baud_o.rx_clk;
        n_tx += baud_o.tx_clk;
      end
      chk("rx clk", 8'h01, {7'h0, n_rx >= (m ? 9 : 19) && n_rx <= (m ? 11 : 21)});
      chk("tx clk", 8'h01, {7'h0, n_tx >= 19 && n_tx <= 21});
      pin_u.fall(1'b0);
      rchk(TMR_CTRL_ADDR, m ? 8'h1c : 8'h3c, "baud flags");
    end
    // Event counting on count input falls
    wr(TMR_CTRL_ADDR, 8'h06);
    wr(TMR_CNTL_ADDR, 8'h00);
    wr(TMR_CNTH_ADDR, 8'h00);
    repeat (3) pin_u.fall(1'b1);
    rchk(TMR_CNTL_ADDR, 8'h03, "events");
    test_done();
  end
endmodule
